// ### logic/prs_pkg.sv
// Constants for the PLL reference selection block: register map, field codes, counts.
// Assumes an APB master with 32-bit data and word-aligned addresses.
//
// What this block does
// [R1] Each PLL starts in free-run, running from the crystal until a reference is usable.
// [R2] Each PLL has its own selection control; any input can serve either PLL.
// [R3] Automatic mode: a validated reference moves the PLL into the locked state.
// [R4] Automatic mode: active reference fails with none valid, PLL enters holdover at once.
// [R5] Automatic mode: active reference fails, another valid, switch to it hitlessly.
// [R6] Manual mode: one reference per PLL; on its failure holdover, never another input.
// [R7] Manual selection by naming the input in the select field, or pin-controlled mode.
// [R8] Pin-controlled mode: two select pins per PLL, codes 0..3 pick inputs 0..3.
// [R9] Automatic mode: each input has a priority 1 to 4 in per-PLL priority registers.
// [R10] At start or on failure, automatic mode picks highest-priority valid input.
// [R11] Revertive mode switches to any higher-priority input once it becomes valid.
// [R12] Non-revertive mode keeps the active input while it stays valid.
// [R13] Software should give each input of one PLL a distinct priority.
// [R14] Bypass pin high: input 0 drives output 4 dividers, input 1 drives output 5.
// [R15] Inputs 0..2 feed outputs 4..7 dividers only at or below the frequency limit; the source codes here offer inputs 0 and 1 only.
// [R16] A path routes the crystal straight to the dividers of outputs 4 to 7.
// [R17] Each PLL reports lock and holdover in status register bits and on pins.
// [R18] A lost input becomes valid after 8 rising edges; a new fault restarts count.
// [R19] An input is lost when the monitor count expires twice without an edge.
// [R20] Select field has codes for four direct inputs, pin mode, revertive, non-revertive.
package prs_pkg;
  localparam int NUM_PLL = 2;
  localparam int NUM_REF = 4;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PRIO = 12'h004;
  localparam logic [11:0] ADDR_MON = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_OUTSRC = 12'h010;

  // Control: per PLL a 3-bit select field at bit 8*n
  localparam int CTRL_SEL_STRIDE = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0606;
  // Priority: per PLL four 2-bit fields (value = priority-1) at 8*n
  localparam int PRIO_STRIDE = 8;
  localparam logic [31:0] PRIO_RESET = 32'h0000_e4e4;
  // Monitor count, 17 bits
  localparam int MON_W = 17;
  localparam logic [MON_W-1:0] MON_RESET = 17'h00010;
  // Output 4..7 divider source field, per output 2 bits at 2*k
  localparam logic [31:0] OUTSRC_RESET = 32'h0000_0000;
  // Status bit positions
  localparam int ST_LOCK0 = 0;
  localparam int ST_HOLD0 = 2;
  localparam int ST_ACT0 = 4;
  localparam int ST_LOS0 = 8;

  localparam int VALID_EDGES = 8;

  typedef enum logic [2:0] {
    PRS_SEL_REF0 = 3'h0,
    PRS_SEL_REF1 = 3'h1,
    PRS_SEL_REF2 = 3'h2,
    PRS_SEL_REF3 = 3'h3,
    PRS_SEL_PIN = 3'h4,
    PRS_SEL_AUTO_REV = 3'h5,
    PRS_SEL_AUTO_NREV = 3'h6
  } prs_sel_t;

  typedef enum logic [1:0] {
    PRS_FREERUN = 2'h0,
    PRS_LOCKED = 2'h1,
    PRS_HOLDOVER = 2'h2
  } prs_state_t;

  // Output 4..7 divider source: 0 PLL, 1 crystal, 2 input 0, 3 input 1
  localparam logic [1:0] SRC_PLL = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_REF0 = 2'h2;
  localparam logic [1:0] SRC_REF1 = 2'h3;
endpackage

// ### logic/prs_pll_reference_select.sv
// PLL reference selection, per-PLL state and bypass steering.
// Reference inputs and select/bypass pins are asynchronous and are synchronised here.
`timescale 1ns/100ps
module prs_pll_reference_select import prs_pkg::*; (
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [3:0] ref_input, // Sampled reference inputs 0..3
  input wire logic [3:0] pin_reference_select, // Select pins, [1:0] PLL0, [3:2] PLL1
  input wire logic bypass_select_pin, // Bypass both PLLs
  output logic [1:0] pll_ref_sel, // Input selected by PLL0
  output logic [1:0] pll1_ref_sel, // Input selected by PLL1
  output logic [1:0] lock_pin, // Lock status per PLL
  output logic [1:0] holdover_pin, // Holdover status per PLL
  output logic [3:0] los_flag, // Loss of signal per input
  output logic [7:0] out_div_src // Source codes for dividers of outputs 4..7
);
  logic [3:0] refMeta, refSync, refPrev;
  logic [3:0] pinMeta, pinSync;
  logic bypMeta, bypSync;
  logic [31:0] ctrlReg, prioReg, outSrcReg;
  logic [MON_W-1:0] monReg;
  logic [3:0] los;
  logic [3:0] softAlarm;
  logic [MON_W-1:0] monCnt [NUM_REF];
  logic [3:0] edgeCnt [NUM_REF];
  prs_state_t pllState [NUM_PLL];
  logic [1:0] activeRef [NUM_PLL];
  logic [1:0] next_ref [NUM_PLL];
  logic next_have [NUM_PLL];
  logic [3:0] refRise;
  logic [31:0] statusWord;
  logic access;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      refMeta <= 4'h0;
      refSync <= 4'h0;
      refPrev <= 4'h0;
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      bypMeta <= 1'b0;
      bypSync <= 1'b0;
    end else begin
      refMeta <= ref_input;
      refSync <= refMeta;
      refPrev <= refSync;
      pinMeta <= pin_reference_select;
      pinSync <= pinMeta;
      bypMeta <= bypass_select_pin;
      bypSync <= bypMeta;
    end
  end
  assign refRise = refSync & ~refPrev;

  // Loss monitor per input: first expiry is a soft alarm, second declares loss
  genvar r;
  generate
    for (r = 0; r < NUM_REF; r++) begin : g_mon
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          monCnt[r] <= '0;
          softAlarm[r] <= 1'b0;
          los[r] <= 1'b1;
          edgeCnt[r] <= 4'h0;
        end else begin
          if (refRise[r]) begin
            monCnt[r] <= '0;
            softAlarm[r] <= 1'b0;
          end else if (monCnt[r] >= monReg) begin
            monCnt[r] <= '0;
            softAlarm[r] <= 1'b1;
          end else begin
            monCnt[r] <= monCnt[r] + 1'b1;
          end
          if (!refRise[r] && monCnt[r] >= monReg && softAlarm[r]) begin
            los[r] <= 1'b1; // R19
            edgeCnt[r] <= 4'h0; // R18
          end else if (los[r] && refRise[r]) begin
            if (edgeCnt[r] == 4'(VALID_EDGES - 1)) begin
              los[r] <= 1'b0; // R18
              edgeCnt[r] <= 4'h0;
            end else begin
              edgeCnt[r] <= edgeCnt[r] + 4'h1;
            end
          end
        end
      end
    end
  endgenerate

  // Per-PLL selection and state machine
  genvar p;
  generate
    for (p = 0; p < NUM_PLL; p++) begin : g_pll
      prs_sel_t sel;
      logic [1:0] prio [NUM_REF];
      assign sel = prs_sel_t'(ctrlReg[p*CTRL_SEL_STRIDE +: 3]); // R2
      for (genvar k = 0; k < NUM_REF; k++) begin : g_pr
        assign prio[k] = prioReg[p*PRIO_STRIDE + 2*k +: 2]; // R9
      end
      // Lower stored code means higher priority; lower index breaks ties
      always_comb begin
        logic [1:0] best;
        logic found;
        best = 2'h0;
        found = 1'b0;
        for (int k = 0; k < NUM_REF; k++) begin
          if (!los[k] && (!found || prio[k] < prio[best])) begin
            best = 2'(k);
            found = 1'b1;
          end
        end
        next_ref[p] = best; // R10
        next_have[p] = found;
        if (sel == PRS_SEL_PIN) begin
          next_ref[p] = pinSync[2*p +: 2]; // R7 R8
          next_have[p] = !los[pinSync[2*p +: 2]];
        end else if (sel <= PRS_SEL_REF3) begin
          next_ref[p] = sel[1:0]; // R7
          next_have[p] = !los[sel[1:0]];
        end
      end
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pllState[p] <= PRS_FREERUN; // R1
          activeRef[p] <= 2'h0;
        end else begin
          unique case (pllState[p])
            PRS_FREERUN, PRS_HOLDOVER: begin
              if (next_have[p]) begin
                pllState[p] <= PRS_LOCKED; // R3
                activeRef[p] <= next_ref[p];
              end
            end
            PRS_LOCKED: begin
              if (sel <= PRS_SEL_PIN) begin
                // Manual: follow the chosen input only, hold over on its loss
                activeRef[p] <= next_ref[p]; // R6
                if (!next_have[p]) pllState[p] <= PRS_HOLDOVER; // R6
              end else if (los[activeRef[p]]) begin
                if (next_have[p]) begin
                  activeRef[p] <= next_ref[p]; // R5 R10
                end else begin
                  pllState[p] <= PRS_HOLDOVER; // R4
                end
              end else if (sel == PRS_SEL_AUTO_REV && next_have[p]
                           && prio[next_ref[p]] < prio[activeRef[p]]) begin
                activeRef[p] <= next_ref[p]; // R11
              end
              // Non-revertive keeps the active input while it is valid R12
            end
            default: pllState[p] <= PRS_FREERUN;
          endcase
        end
      end
      assign lock_pin[p] = (pllState[p] == PRS_LOCKED); // R17
      assign holdover_pin[p] = (pllState[p] == PRS_HOLDOVER); // R17
    end
  endgenerate
  assign pll_ref_sel = activeRef[0];
  assign pll1_ref_sel = activeRef[1];
  assign los_flag = los;

  // Output 4..7 divider source steering; bypass overrides outputs 4 and 5
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_div_src <= 8'h00;
    end else begin
      out_div_src <= outSrcReg[7:0]; // R16
      if (bypSync) begin
        out_div_src[1:0] <= SRC_REF0; // R14
        out_div_src[3:2] <= SRC_REF1; // R14
      end
    end
  end

  // APB slave, zero wait states
  assign access = psel && penable;
  assign pready = 1'b1;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrlReg <= CTRL_RESET;
      prioReg <= PRIO_RESET;
      monReg <= MON_RESET;
      outSrcReg <= OUTSRC_RESET;
    end else if (access && pwrite) begin
      unique case (paddr)
        ADDR_CTRL: ctrlReg <= pwdata & 32'h0000_0707; // R20
        ADDR_PRIO: prioReg <= pwdata & 32'h0000_ffff;
        ADDR_MON: monReg <= pwdata[MON_W-1:0];
        ADDR_OUTSRC: outSrcReg <= pwdata & 32'h0000_00ff; // R15
        default: ;
      endcase
    end
  end

  always_comb begin
    statusWord = 32'h0;
    statusWord[ST_LOCK0 +: 2] = lock_pin; // R17
    statusWord[ST_HOLD0 +: 2] = holdover_pin; // R17
    statusWord[ST_ACT0 +: 4] = {activeRef[1], activeRef[0]};
    statusWord[ST_LOS0 +: 4] = los;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(paddr inside {ADDR_CTRL, ADDR_PRIO, ADDR_MON, ADDR_STATUS, ADDR_OUTSRC});
        unique case (paddr)
          ADDR_CTRL: prdata <= ctrlReg;
          ADDR_PRIO: prdata <= prioReg;
          ADDR_MON: prdata <= {15'h0, monReg};
          ADDR_STATUS: prdata <= statusWord;
          ADDR_OUTSRC: prdata <= outSrcReg;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // prs_pll_reference_select

// ### verification/prs_pll_reference_select_sva.sv
// Checker for the reference select block, bound to its top module.
// Assumes the reset monitor count and slow reference toggles.
`timescale 1ns/100ps
module prs_pll_reference_select_sva import prs_pkg::*; (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic [3:0] ref_input, // References
  input wire logic bypass_select_pin, // Bypass
  input wire logic [1:0] pll_ref_sel, // PLL0 input
  input wire logic [1:0] pll1_ref_sel, // PLL1 input
  input wire logic [1:0] lock_pin, // Lock
  input wire logic [1:0] holdover_pin, // Holdover
  input wire logic [3:0] los_flag, // Loss
  input wire logic [7:0] out_div_src // Sources
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic prev0;
  logic [7:0] quiet;
  always_ff @(posedge ref_clk) begin
    prev0 <= ref_input[0];
    if (sys_rst || ref_input[0] != prev0) quiet <= 8'h00;
    else if (quiet != 8'hff) quiet <= quiet + 8'h01;
  end
  property p_free; $fell(sys_rst) |-> lock_pin == 2'h0 && holdover_pin == 2'h0; endproperty
  a_free: assert property (p_free) else $error("not free-run after reset");
  property p_byp; bypass_select_pin [*5] |-> out_div_src[3:0] == 4'he; endproperty
  a_byp: assert property (p_byp) else $error("bypass routing wrong");
  property p_hold0; $rose(holdover_pin[0]) |-> los_flag[pll_ref_sel]; endproperty
  a_hold0: assert property (p_hold0) else $error("PLL0 holdover on good input");
  property p_hold1; $rose(holdover_pin[1]) |-> los_flag[pll1_ref_sel]; endproperty
  a_hold1: assert property (p_hold1) else $error("PLL1 holdover on good input");
  property p_lost;
    lock_pin[0] && los_flag[pll_ref_sel] |=> !lock_pin[0] || pll_ref_sel != $past(pll_ref_sel);
  endproperty
  a_lost: assert property (p_lost) else $error("locked to lost input");
  property p_valid; $rose(los_flag[0]) |=> los_flag[0] [*8]; endproperty
  a_valid: assert property (p_valid) else $error("loss cleared too soon");
  property p_quiet; $rose(los_flag[0]) |-> quiet >= 8'h20; endproperty
  a_quiet: assert property (p_quiet) else $error("loss flagged too early");
  property p_stat;
    psel && penable && !pwrite && paddr == ADDR_STATUS |->
      prdata[3:0] == {$past(holdover_pin), $past(lock_pin)} && prdata[11:8] == $past(los_flag);
  endproperty
  a_stat: assert property (p_stat) else $error("status bits differ from pins");
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  c_hold: cover property (holdover_pin[0]);
  c_byp: cover property (bypass_select_pin && out_div_src[3:0] == 4'he);
  c_lock: cover property (lock_pin[1]);
endmodule // prs_pll_reference_select_sva
bind prs_pll_reference_select prs_pll_reference_select_sva u_sva (.ref_clk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .ref_input, .bypass_select_pin, .pll_ref_sel,
  .pll1_ref_sel, .lock_pin, .holdover_pin, .los_flag, .out_div_src);

// ### verification/prs_pll_reference_select_test.sv
// Self-checking bench for the reference select block.
// Assumes reset register values; a stopped source is flagged in about 40 clocks.
`timescale 1ns/100ps
module prs_pll_reference_select_test import prs_pkg::*; ;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic bypass = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [3:0] enable = 4'h0, pinCode = 4'h0, refIn, pinSel, los;
  logic [1:0] sel0, sel1, lock, hold;
  logic [7:0] divSrc;
  int fail_count = 0, compares = 0;
  always #10 ref_clk = ~ref_clk;
  prs_pll_reference_select DUT (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ref_input(refIn), .pin_reference_select(pinSel),
    .bypass_select_pin(bypass), .pll_ref_sel(sel0), .pll1_ref_sel(sel1), .lock_pin(lock),
    .holdover_pin(hold), .los_flag(los), .out_div_src(divSrc));
  prs_ref_source src (.ref_clk, .enable, .pinCode, .ref_input(refIn),
    .pin_reference_select(pinSel));
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Polls with a bound so a stuck state ends as a mismatch, not a hang
  task waitFor(input int p, input logic [1:0] s, input logic [1:0] st);
    logic [3:0] got;
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      got = p ? {hold[1], lock[1], sel1} : {hold[0], lock[0], sel0};
      if (got === {st, s}) break;
    end
    check(32'(got), 32'({st, s}));
  endtask
  task s_reset;
    check(32'({lock, hold}), 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdata, CTRL_RESET);
    apb(1'b0, ADDR_PRIO, 32'h0);
    check(rdata, PRIO_RESET);
    apb(1'b0, ADDR_MON, 32'h0);
    check(rdata, 32'(MON_RESET));
    apb(1'b0, 12'h020, 32'h0);
    check(32'(err), 32'h1);
  endtask
  task s_auto;
    // PLL1 gets the reverse order, each input still a distinct priority
    apb(1'b1, ADDR_PRIO, 32'h0000_1be4);
    enable <= 4'h6;
    waitFor(0, 2'h1, 2'h1);
    waitFor(1, 2'h2, 2'h1);
    enable <= 4'h7;
    repeat (80) @(posedge ref_clk);
    check(32'(sel0), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0505);
    waitFor(0, 2'h0, 2'h1);
    check(32'(sel1), 32'h2);
    enable <= 4'h6;
    waitFor(0, 2'h1, 2'h1);
    enable <= 4'h0;
    waitFor(0, 2'h1, 2'h2);
  endtask
  task s_manual;
    enable <= 4'hf;
    apb(1'b1, ADDR_CTRL, 32'h0403);
    waitFor(0, 2'h3, 2'h1);
    for (int c = 0; c < 4; c++) begin
      pinCode <= 4'(c << 2);
      waitFor(1, 2'(c), 2'h1);
    end
    check(32'(sel0), 32'h3);
    enable <= 4'h7;
    waitFor(0, 2'h3, 2'h2);
    check(32'(los), 32'h8);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rdata, (32'h8 << ST_LOS0) | (32'hf << ST_ACT0) | (32'h3 << ST_HOLD0));
  endtask
  task s_bypass;
    apb(1'b1, ADDR_OUTSRC, 32'h55);
    repeat (2) @(posedge ref_clk);
    check(32'(divSrc), 32'({4{SRC_XTAL}}));
    bypass <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check(32'(divSrc[3:0]), 32'({SRC_REF1, SRC_REF0}));
    bypass <= 1'b0;
  endtask
  task stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    s_reset;
    s_auto;
    s_manual;
    s_bypass;
    stop_test;
  end
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
endmodule // prs_pll_reference_select_test

// ### verification/prs_ref_source.sv
// Reference clock sources and board select pins facing the block.
// Assumes the bench changes requests just after a clock edge.
`timescale 1ns/100ps
module prs_ref_source (
  input wire logic ref_clk, // Clock
  input wire logic [3:0] enable, // Source running
  input wire logic [3:0] pinCode, // Pin request
  output logic [3:0] ref_input, // References
  output logic [3:0] pin_reference_select // Select pins
);
  logic [1:0] phase = 2'h0;
  always_ff @(posedge ref_clk) begin
    phase <= phase + 2'h1;
  end
  // Four-clock period stays under the divider limit; a stopped source sits at its pulldown
  assign ref_input = enable & {4{phase[1]}};
  assign pin_reference_select = pinCode;
endmodule // prs_ref_source
